// ---- crbsm_pkg.sv ----
// Package of constants, states and carrier types for the command buffer state machine
package crbsm_pkg;

    // Register byte offsets on the plain register port
    localparam logic [7:0] OFF_REQ = 8'h00;       // Request register: command-ready, go-idle
    localparam logic [7:0] OFF_STS = 8'h04;       // Status register: fatal error, idle
    localparam logic [7:0] OFF_CANCEL = 8'h08;    // Cancel request register
    localparam logic [7:0] OFF_START = 8'h0C;     // Start request register
    localparam logic [7:0] OFF_CAP = 8'h10;       // Interface capability register
    localparam logic [7:0] OFF_STATE = 8'h14;     // Current state code, read only

    // Buffer window: upper half of the address space, one word per slot
    localparam int BUF_SEL_BIT = 7;               // Address bit that selects the buffer
    localparam int BUF_IDX_LSB = 2;               // Lowest word index bit
    localparam int BUF_IDX_MSB = 6;               // Highest word index bit
    localparam int BUF_WORDS = 32;                // Buffer depth in words
    localparam logic [4:0] BUF_BASE = 5'h00;      // Base word index of the buffer

    // Field positions
    localparam int REQ_CR_BIT = 0;                // Command-ready request
    localparam int REQ_GI_BIT = 1;                // Go-idle request
    localparam int STS_FATAL_BIT = 0;             // Fatal error status
    localparam int STS_IDLE_BIT = 1;              // Idle indication
    localparam int CTL_BIT = 0;                   // Start, cancel and bypass bit

    // Reset values
    localparam logic CAP_BYPASS_RST = 1'b0;       // Idle bypass off after reset
    localparam logic FATAL_VALUE = 1'b0;          // No fatal error source in this block

    // Response codes written into word zero when a command ends
    localparam logic [31:0] RC_SUCCESS = 32'h0000_0000;
    localparam logic [31:0] RC_CANCELLED = 32'h0000_0001;

    // Timing
    localparam int CLK_NS = 25;                   // 40 MHz system clock
    localparam int INIT_NS = 1000;                // Init phase length
    localparam int EXEC_NS = 2000;                // Command processing time
    localparam int TMR_W = 12;                    // Timer counter width
    localparam logic [TMR_W-1:0] INIT_CYC = TMR_W'((INIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] EXEC_CYC = TMR_W'((EXEC_NS + CLK_NS - 1) / CLK_NS);

    // Interface states
    typedef enum logic [2:0] {
        ST_INIT,
        ST_IDLE,
        ST_READY,
        ST_RECEPTION,
        ST_EXECUTION,
        ST_COMPLETION
    } crbsm_state_e;

    // One register port request
    typedef struct packed {
        logic wr;                                 // Write strobe
        logic rd;                                 // Read strobe
        logic [7:0] addr;                         // Byte address
        logic [31:0] wdata;                       // Write data
    } crbsm_req_s;

endpackage : crbsm_pkg

// ---- crbsm_timer.sv ----
// Countdown timer with start, abort and a one-cycle done pulse
module crbsm_timer #(
    parameter int unsigned W = 12,
    parameter logic [W-1:0] LOAD = '0,
    parameter bit AUTO = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    input wire logic abort_i,
    // Status
    output logic busy_o,
    output logic done_o
);
    logic [W-1:0] cnt_q;     // Cycles left
    logic busy_q;            // Running
    logic done_q;            // Expiry pulse

    // Count down; an auto timer starts running straight out of reset
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= AUTO ? LOAD : '0;
            busy_q <= AUTO;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start_i) begin
                cnt_q <= LOAD;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                // Abort ends the run at once, so a cancel never waits out the count
                if (abort_i || cnt_q == '0) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - W'(1);
                end
            end
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
endmodule : crbsm_timer

// ---- crbsm_rdseq.sv ----
// Tracker of sequential response reads, restarting at the base word
module crbsm_rdseq (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Control
    input wire logic clear_i,
    input wire logic rd_i,
    input wire logic [4:0] idx_i,
    // Verdict
    output logic ok_o
);
    import crbsm_pkg::*;

    logic [4:0] exp_q;       // Next expected word index

    // A read is in order at the base or at the expected word
    assign ok_o = (idx_i == BUF_BASE) || (idx_i == exp_q);

    // Advance on every accepted read; a base read restarts the count
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            exp_q <= BUF_BASE;
        end else if (clear_i) begin
            exp_q <= BUF_BASE;
        end else if (rd_i && ok_o) begin
            exp_q <= idx_i + 5'h01;
        end
    end
endmodule : crbsm_rdseq

// ---- crbsm_ctrl.sv ----
// Command/response buffer interface state machine with register port and buffer
//
// Operation
// - Ready plus go-idle goes to Idle
// - Buffer write in Ready starts Reception
// - Start in Ready is ignored
// - Cancel in Ready is ignored
// - Buffer reads in Ready are ignored
// - Start in Reception begins Execution
// - Cancel and reads ignored in Reception
// - Command-ready in Reception returns to Ready
// - Go-idle in Reception abandons command
// - Repeated start ignored, start stays set
// - Requests ignored during Execution
// - Processing end clears start, enters Completion
// - Cancel in Execution leads to Completion
// - Buffer accesses ignored in Execution
// - Command-ready in Completion needs idle bypass
// - Bypass write in Completion starts Reception
// - Go-idle in Completion invalidates, goes Idle
// - Start and cancel ignored in Completion
// - Sequential reads return held response
// - Out-of-order reads ignored in Completion
// - Base address read restarts response
// - Init reaches Idle within the limit
// - Command-ready in Idle goes to Ready
// - Buffer accesses ignored in Idle
//
// The placing of the registers and the address-and-strobe port were decided locally.
module crbsm_ctrl (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Register port
    input wire crbsm_pkg::crbsm_req_s req_i,
    output logic [31:0] rd_data_o,
    // Status pins
    output logic idle_indication_o,
    output logic start_request_o
);
    import crbsm_pkg::*;

    // Bounds used by the checks below
    localparam int INIT_BOUND = 60;           // Cycles allowed from reset to Idle
    localparam int CANCEL_BOUND = 3;          // Cycles allowed from cancel to Completion

    crbsm_state_e state_q;                    // Current state
    crbsm_state_e state_d;                    // Next state
    logic idle_q;                             // Idle indication
    logic start_q;                            // Start request field
    logic cancel_q;                           // Cancel request field
    logic bypass_q;                           // Idle bypass capability
    logic buf_valid_q;                        // Buffer holds a response
    logic [31:0] rd_data_q;                   // Registered read data
    logic [31:0] buf_q [BUF_WORDS];           // Command and response words

    // Decoded accesses
    logic wr_req;                             // Write to the request register
    logic cr_w;                               // Command-ready written as one
    logic gi_w;                               // Go-idle written as one
    logic st_w;                               // Start written as one
    logic cc_w;                               // Cancel written as one
    logic buf_wr;                             // Write into the buffer window
    logic buf_rd;                             // Read from the buffer window
    logic [4:0] buf_idx;                      // Buffer word index
    logic buf_wr_ok;                          // Buffer write accepted
    logic seq_ok;                             // Read is in sequence
    logic resp_rd;                            // Response read accepted

    // Engine handshakes
    logic init_busy;                          // Init phase still running
    logic init_done;                          // Init phase finished
    logic exe_busy;                           // Command processing running
    logic exe_done;                           // Command processing ended
    logic exe_go;                             // Launch command processing

    // Address and strobe decode
    assign wr_req = req_i.wr && req_i.addr == OFF_REQ;
    assign cr_w = wr_req && req_i.wdata[REQ_CR_BIT];
    assign gi_w = wr_req && req_i.wdata[REQ_GI_BIT];
    assign st_w = req_i.wr && req_i.addr == OFF_START && req_i.wdata[CTL_BIT];
    assign cc_w = req_i.wr && req_i.addr == OFF_CANCEL && req_i.wdata[CTL_BIT];
    assign buf_wr = req_i.wr && req_i.addr[BUF_SEL_BIT];
    assign buf_rd = req_i.rd && req_i.addr[BUF_SEL_BIT];
    assign buf_idx = req_i.addr[BUF_IDX_MSB:BUF_IDX_LSB];

    // Buffer writes land only while a command may be composed
    assign buf_wr_ok = buf_wr && (state_q == ST_READY || state_q == ST_RECEPTION ||
                                  (state_q == ST_COMPLETION && bypass_q));

    // Reads answer only in Completion, with a valid response and in order
    assign resp_rd = buf_rd && state_q == ST_COMPLETION && buf_valid_q && seq_ok;

    // Launch processing on the move into Execution
    assign exe_go = state_q == ST_RECEPTION && state_d == ST_EXECUTION;

    // Init phase timer, running from reset
    crbsm_timer #(
        .W(TMR_W),
        .LOAD(INIT_CYC),
        .AUTO(1'b1)
    ) u_init_tmr (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .start_i(1'b0),
        .abort_i(1'b0),
        .busy_o(init_busy),
        .done_o(init_done)
    );

    // Command processing timer; cancel cuts it short
    crbsm_timer #(
        .W(TMR_W),
        .LOAD(EXEC_CYC),
        .AUTO(1'b0)
    ) u_exec_tmr (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .start_i(exe_go),
        .abort_i(cc_w && state_q == ST_EXECUTION),
        .busy_o(exe_busy),
        .done_o(exe_done)
    );

    // Response read order tracker, cleared whenever a response is posted
    crbsm_rdseq u_rdseq (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .clear_i(exe_done),
        .rd_i(resp_rd),
        .idx_i(buf_idx),
        .ok_o(seq_ok)
    );

    // Next state; go-idle takes priority where two requests share a write
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_INIT: begin
                // Wait out the init phase
                if (init_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // Buffer traffic has no effect here
                if (cr_w && !gi_w) begin
                    state_d = ST_READY;
                end
            end
            ST_READY: begin
                // Start, cancel and reads leave the state alone
                if (gi_w) begin
                    state_d = ST_IDLE;
                end else if (buf_wr) begin
                    state_d = ST_RECEPTION;
                end
            end
            ST_RECEPTION: begin
                // Further buffer writes simply add command data
                if (gi_w) begin
                    state_d = ST_IDLE;
                end else if (cr_w) begin
                    state_d = ST_READY;
                end else if (st_w) begin
                    state_d = ST_EXECUTION;
                end
            end
            ST_EXECUTION: begin
                // Only the end of processing moves on
                if (exe_done) begin
                    state_d = ST_COMPLETION;
                end
            end
            ST_COMPLETION: begin
                // Without bypass, only go-idle leaves
                if (gi_w) begin
                    state_d = ST_IDLE;
                end else if (cr_w && bypass_q) begin
                    state_d = ST_READY;
                end else if (buf_wr && bypass_q) begin
                    state_d = ST_RECEPTION;
                end
            end
            default: begin
                // An illegal code recovers through Idle
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Idle and start follow the next state, so they change with the state itself
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            idle_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            idle_q <= state_d == ST_IDLE;
            start_q <= state_d == ST_EXECUTION;
        end
    end

    // Cancel field holds only while a command executes
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cancel_q <= 1'b0;
        end else if (state_d != ST_EXECUTION) begin
            cancel_q <= 1'b0;
        end else if (cc_w) begin
            cancel_q <= 1'b1;
        end
    end

    // Capability register, written by software
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bypass_q <= CAP_BYPASS_RST;
        end else if (req_i.wr && req_i.addr == OFF_CAP) begin
            bypass_q <= req_i.wdata[CTL_BIT];
        end
    end

    // Response validity; go-idle or a new command throws the response away
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            buf_valid_q <= 1'b0;
        end else if (exe_done) begin
            buf_valid_q <= 1'b1;
        end else if (state_q == ST_COMPLETION && state_d != ST_COMPLETION) begin
            buf_valid_q <= 1'b0;
        end
    end

    // Buffer store; processing end overwrites word zero with the result code.
    // The array has no reset, which keeps it in plain memory cells.
    always_ff @(posedge clk_sys_i) begin
        if (exe_done) begin
            buf_q[BUF_BASE] <= cancel_q ? RC_CANCELLED : RC_SUCCESS;
        end else if (buf_wr_ok) begin
            buf_q[buf_idx] <= req_i.wdata;
        end
    end

    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_q <= 32'h0000_0000;
        end else if (!req_i.rd) begin
            rd_data_q <= 32'h0000_0000;
        end else if (req_i.addr[BUF_SEL_BIT]) begin
            // Response stays in the buffer after reading
            rd_data_q <= resp_rd ? buf_q[buf_idx] : 32'h0000_0000;
        end else begin
            unique case (req_i.addr)
                OFF_STS: rd_data_q <= 32'({idle_q, FATAL_VALUE});
                OFF_CANCEL: rd_data_q <= 32'(cancel_q);
                OFF_START: rd_data_q <= 32'(start_q);
                OFF_CAP: rd_data_q <= 32'(bypass_q);
                OFF_STATE: rd_data_q <= 32'(state_q);
                // Request register and holes read as zero
                default: rd_data_q <= 32'h0000_0000;
            endcase
        end
    end

    assign rd_data_o = rd_data_q;
    assign idle_indication_o = idle_q;
    assign start_request_o = start_q;

    // Checks
    AST_READY_GO_IDLE_REQUEST: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_READY && gi_w |=> state_q == ST_IDLE && idle_indication_o)
        else $error("Go-idle in Ready did not reach Idle");

    AST_READY_RECV: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_READY && buf_wr |-> buf_wr_ok ##1 state_q == ST_RECEPTION && !idle_indication_o)
        else $error("Buffer write in Ready did not start Reception");

    AST_READY_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_READY && (st_w || cc_w || buf_rd) |=> state_q == ST_READY && !start_request_o)
        else $error("Ready left on an ignored request");

    AST_RECV_START: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_RECEPTION && st_w |=> start_request_o [*2])
        else $error("Start in Reception did not hold start");

    AST_RECV_READY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_RECEPTION && cr_w && !gi_w |=> state_q == ST_READY)
        else $error("Command-ready in Reception did not return to Ready");

    AST_RECV_ABORT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_RECEPTION && gi_w |=> idle_indication_o && !start_request_o)
        else $error("Go-idle in Reception did not abort");

    AST_EXEC_STAY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_EXECUTION && wr_req && !exe_done |=> state_q == ST_EXECUTION)
        else $error("Request left Execution");

    AST_EXEC_END: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        exe_done |=> state_q == ST_COMPLETION && !start_request_o && !cancel_q)
        else $error("Processing end did not clear start");

    AST_CANCEL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_EXECUTION && cc_w |-> ##[1:CANCEL_BOUND] state_q == ST_COMPLETION)
        else $error("Cancel did not reach Completion in time");

    AST_NO_BYPASS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_COMPLETION && cr_w && !gi_w && !bypass_q |=> state_q == ST_COMPLETION)
        else $error("Command-ready without bypass left Completion");

    AST_RECV_DATA: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_RECEPTION && buf_wr |-> buf_wr_ok ##1 state_q == ST_RECEPTION)
        else $error("Buffer write in Reception was not taken as command data");

    AST_EXEC_BUF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_EXECUTION && !exe_done && (buf_wr || buf_rd) |->
        !buf_wr_ok && !resp_rd ##1 state_q == ST_EXECUTION && rd_data_o == 32'h0000_0000)
        else $error("Buffer access during Execution was not ignored");

    AST_COMP_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_COMPLETION && (st_w || cc_w) |=> state_q == ST_COMPLETION && !start_request_o && !cancel_q)
        else $error("Start or cancel left Completion");

    AST_COMP_GO_IDLE_REQUEST: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_COMPLETION && gi_w |=> state_q == ST_IDLE && idle_indication_o && !buf_valid_q)
        else $error("Go-idle in Completion did not invalidate and reach Idle");

    AST_BASE_REREAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_COMPLETION && buf_rd && buf_idx == BUF_BASE |=>
        rd_data_o == $past(buf_q[BUF_BASE]))
        else $error("Base read did not return the first word");

    AST_INIT_IDLE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_q == ST_INIT |-> ##[0:INIT_BOUND] idle_indication_o)
        else $error("Init did not reach Idle in time");

    AST_IDLE_ONLY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (idle_indication_o == (state_q == ST_IDLE)) && (start_request_o == (state_q == ST_EXECUTION)))
        else $error("Idle or start disagrees with state");
endmodule : crbsm_ctrl

// ---- crbsm_host.sv ----
// Host software model that drives the register port of the command buffer block
module crbsm_host (
    // Clock
    input wire logic clk_sys_i,
    // Register port
    output crbsm_pkg::crbsm_req_s req_o,
    input wire logic [31:0] rd_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import crbsm_pkg::*;

    // Quiet bus from time zero, so no strobe is seen during reset
    initial begin
        req_o = '0;
    end

    // One write cycle: launched after an edge, held until the taking edge, then dropped
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        req_o.wr <= 1'b0;
    endtask : bus_wr

    // One read cycle; data stands only in the cycle after the strobe, so sample it mid-cycle
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk_sys_i);
        req_o.rd <= 1'b0;
        @(negedge clk_sys_i);
        d = rd_data_i;
    endtask : bus_rd

endmodule : crbsm_host

// ---- crbsm_ctrl_tb.sv ----
// Self-checking testbench for the command buffer state machine
module crbsm_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import crbsm_pkg::*;

    logic clk_sys_i; // System clock
    logic rst_i; // Asynchronous reset, active high
    crbsm_req_s req; // Request from the host model
    logic [31:0] rd_data; // Read data back from the block
    logic idle_ind; // Idle indication pin
    logic start_req; // Start request pin
    int n_mismatch; // Mismatches seen
    int cmp_count; // Comparisons made
    logic [31:0] seed; // Xorshift state, fixed start keeps runs repeatable
    logic [31:0] exp_w [4]; // Command words written, expected back in the response
    logic [31:0] d; // Last read value

    // Device under test
    crbsm_ctrl crbsm_ctrl_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .rd_data_o(rd_data),
        .idle_indication_o(idle_ind), .start_request_o(start_req));

    // Host software on the far side of the register port
    crbsm_host crbsm_host_i (.clk_sys_i(clk_sys_i), .req_o(req), .rd_data_i(rd_data));

    // 40 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // Random word source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Verdict and end of run
    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // Single comparison point
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bus shorthands
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        crbsm_host_i.bus_wr(a, v);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        crbsm_host_i.bus_rd(a, d);
    endtask : rd

    // State code plus both pins; idle only in Idle, start only in Execution
    task automatic st(input logic [2:0] e);
        rd(OFF_STATE);
        chk(d, {29'h0, e});
        chk({31'h0, idle_ind}, {31'h0, e == 3'h1});
        chk({31'h0, start_req}, {31'h0, e == 3'h4});
    endtask : st

    // Bounded wait for idle high or for start low; a hang counts as a mismatch
    task automatic wait_pin(input logic want_idle, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk_sys_i);
            if (want_idle ? (idle_ind === 1'b1) : (start_req === 1'b0)) return;
        end
        n_mismatch++;
        $display("BAD %0t: wait ran out", $time);
        wrap_up();
    endtask : wait_pin

    // Write n random command words from the base upward
    task automatic fill(input int n);
        for (int i = 0; i < n; i++) begin
            exp_w[i] = xs();
            wr(8'h80 + 8'(i * 4), exp_w[i]);
        end
    endtask : fill

    // Main sequence
    initial begin
        rst_i = 1'b1;
        n_mismatch = 0;
        cmp_count = 0;
        seed = 32'h7607;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        wait_pin(1'b1, 100);
        st(3'h1);
        // Buffer traffic in Idle goes nowhere
        wr(8'h80, xs());
        rd(8'h80);
        chk(d, 32'h0000_0000);
        st(3'h1);
        wr(OFF_REQ, 32'h0000_0001);
        st(3'h2);
        // Requests without a command in Ready
        wr(OFF_START, 32'h0000_0001);
        wr(OFF_CANCEL, 32'h0000_0001);
        rd(OFF_CANCEL);
        chk(d, 32'h0000_0000);
        rd(8'h80);
        chk(d, 32'h0000_0000);
        st(3'h2);
        wr(OFF_REQ, 32'h0000_0002);
        st(3'h1);
        // Reception entry and its exits
        wr(OFF_REQ, 32'h0000_0001);
        fill(2);
        st(3'h3);
        wr(OFF_CANCEL, 32'h0000_0001);
        rd(8'h80);
        chk(d, 32'h0000_0000);
        st(3'h3);
        wr(OFF_REQ, 32'h0000_0001);
        st(3'h2);
        fill(1);
        wr(OFF_REQ, 32'h0000_0002);
        st(3'h1);
        // Full command; requests during Execution must not disturb it
        wr(OFF_REQ, 32'h0000_0001);
        fill(4);
        wr(OFF_START, 32'h0000_0001);
        st(3'h4);
        wr(OFF_START, 32'h0000_0001);
        wr(OFF_REQ, 32'h0000_0001);
        wr(OFF_REQ, 32'h0000_0002);
        wr(8'h84, ~exp_w[1]);
        rd(8'h80);
        chk(d, 32'h0000_0000);
        rd(OFF_START);
        chk(d, 32'h0000_0001);
        st(3'h4);
        wait_pin(1'b0, 200);
        st(3'h5);
        // Response reads: sequential, out of order, then a restart from the base
        rd(8'h80);
        chk(d, RC_SUCCESS);
        rd(8'h84);
        chk(d, exp_w[1]);
        rd(8'h8C);
        chk(d, 32'h0000_0000);
        rd(8'h80);
        chk(d, RC_SUCCESS);
        rd(8'h84);
        chk(d, exp_w[1]);
        rd(8'h88);
        chk(d, exp_w[2]);
        wr(OFF_START, 32'h0000_0001);
        wr(OFF_CANCEL, 32'h0000_0001);
        st(3'h5);
        // Bypass still off, so neither command-ready nor a buffer write leaves Completion
        wr(OFF_REQ, 32'h0000_0001);
        wr(8'h80, xs());
        st(3'h5);
        rd(8'h80);
        chk(d, RC_SUCCESS);
        wr(OFF_REQ, 32'h0000_0002);
        st(3'h1);
        // Cancelled command with bypass enabled
        wr(OFF_CAP, 32'h0000_0001);
        wr(OFF_REQ, 32'h0000_0001);
        fill(2);
        wr(OFF_START, 32'h0000_0001);
        wr(OFF_CANCEL, 32'h0000_0001);
        wait_pin(1'b0, 4);
        rd(OFF_CANCEL);
        chk(d, 32'h0000_0000);
        st(3'h5);
        rd(8'h80);
        chk(d, RC_CANCELLED);
        wr(OFF_REQ, 32'h0000_0001);
        st(3'h2);
        fill(1);
        wr(OFF_START, 32'h0000_0001);
        wait_pin(1'b0, 200);
        fill(1);
        st(3'h3);
        wrap_up();
    end

endmodule : crbsm_ctrl_tb
